//--- core/lpm_pkg.sv
package lpm_pkg;

    // ====
    // register map
    localparam logic [7:0] LPM_REG_CTRL = 8'h00;
    localparam logic [7:0] LPM_REG_STATUS = 8'h04;
    localparam logic [7:0] LPM_REG_HALT_WAKE = 8'h08;
    localparam logic [7:0] LPM_REG_ACT_WAKE = 8'h0c;

    // ====
    // reset values
    localparam logic [8:0] LPM_CTRL_RESET = 9'h000;
    // halt wake lines
    localparam logic [13:0] LPM_HALT_WAKE_RESET = 14'h101e;
    // active halt wake lines
    localparam logic [13:0] LPM_ACT_WAKE_RESET = 14'h0a00;
    // auto wakeup halt line
    localparam logic [13:0] LPM_AWU_WAKE = 14'h0001;
    localparam logic LPM_CC_I_RESET = 1'b1;

    // ====
    // opcodes and field positions
    localparam logic [7:0] LPM_HALT_OPCODE = 8'h8e;
    localparam int LPM_IRQ_NUM = 14;
    localparam int LPM_STATUS_MODE_LSB = 0;
    localparam int LPM_STATUS_VEC_LSB = 4;
    localparam int LPM_STATUS_RST_BIT = 8;
    localparam int LPM_STATUS_CCI_BIT = 9;

    // ====
    // timing
    localparam int LPM_CLK_PERIOD_PS = 5000;
    localparam logic [12:0] LPM_STAB_SHORT_CYC = 13'd256;
    localparam logic [12:0] LPM_STAB_LONG_CYC = 13'd4096;
    localparam int LPM_PLL_SETTLE_NS = 1000;
    localparam logic [12:0] LPM_PLL_SETTLE_CYC =
        13'((LPM_PLL_SETTLE_NS * 1000 + LPM_CLK_PERIOD_PS - 1) / LPM_CLK_PERIOD_PS);

    // ====
    // types
    typedef enum logic [2:0]
    {
        LPM_RUN,
        LPM_WAIT,
        LPM_HALT,
        LPM_ACT_HALT,
        LPM_AWU_HALT,
        LPM_STAB,
        LPM_PLL
    } lpm_mode_e;

    typedef struct packed
    {
        logic pll_enable;
        logic long_stab;
        logic watchdog_enable;
        logic watchdog_halt_option;
        logic auto_wakeup_enable;
        logic timer_source_select_hi;
        logic timer_source_select_lo;
        logic overflow_irq_enable;
        logic timebase_one_irq_enable;
    } lpm_ctrl_s;

    typedef struct packed
    {
        logic cpu_run;
        logic periph_clk_en;
        logic osc_en;
        logic timer_clk_en;
        logic pll_out_en;
    } lpm_clk_s;

endpackage

//--- core/lpm_stab_timer.sv
`timescale 1ns/1ps
module lpm_stab_timer
    import lpm_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic start,
    input wire logic [12:0] length,
    // result
    output logic done
);

    logic [12:0] count;
    logic [12:0] next_count;

    // ==========================================================
    // down counter
    always_comb
    begin
        next_count = count;
        if (start)
        begin
            next_count = length;
        end
        else if (count != 13'h0000)
        begin
            next_count = count - 13'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 13'h0000;
        end
        else
        begin
            count <= next_count;
        end
    end

    // done pulse, registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done <= 1'b0;
        end
        else
        begin
            done <= !start && (count == 13'h0001);
        end
    end

endmodule

//--- core/lpm_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// R1: wait op stops cpu, peripherals run
// R2: wait entry clears interrupt mask bit
// R3: wait ends on reset or interrupt
// R4: service sets mask, pop clears it
// R5: halt only without active halt, autowake
// R6: halt exit restarts oscillator, 256/4096 delay; autowake halt exit waits 256 even with long_stab
// R7: halt entry forces mask to zero
// R8: halt stops oscillator and all clocks
// R9: option decides watchdog reset on halt
// R10: opcode 8e is the halt instruction
// R11: active halt chosen from timer enables
// R12: active halt reset exit waits 256
// R13: active halt interrupt exit resumes at once
// R14: active halt entry clears mask
// R15: active halt keeps oscillator and timer only
// R16: active halt never gives watchdog reset
// R17: only selected interrupts wake active halt
// R18: pll clock only after settle delay; active halt interrupt exit and a pll_enable write in run give it at once
// R19: software clears pending flags before halt
// R20: halt with autowake enters autowake halt
// R21: mode chosen same cycle, exactly one
module lpm_ctrl
    import lpm_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // cpu core side
    input wire logic instr_exec,
    input wire logic [7:0] instr_opcode,
    input wire logic wait_for_irq_op,
    input wire logic cc_pop,
    input wire logic reset_req,
    input wire logic [13:0] irq_pending,
    // wake results
    output logic irq_service,
    output logic [3:0] irq_vector,
    output logic reset_fetch,
    output logic watchdog_reset_req,
    output logic condition_code_reg,
    // clock gating
    output logic cpu_run,
    output logic periph_clk_en,
    output logic osc_en,
    output logic timer_clk_en,
    output logic pll_out_en
);

    // ==========================================================
    // declarations
    lpm_mode_e state;
    lpm_mode_e next_state;
    lpm_ctrl_s ctrl;
    lpm_clk_s next_clk;
    logic [13:0] halt_wake;
    logic [13:0] act_wake;
    logic halt_exec;
    logic active_halt_en;
    logic [13:0] wait_hits;
    logic [13:0] halt_hits;
    logic [13:0] act_hits;
    logic [13:0] awu_hits;
    logic [13:0] sel_hits;
    logic [3:0] sel_vec;
    logic sel_any;
    logic [3:0] wake_vec;
    logic wake_by_reset;
    logic next_service;
    logic next_fetch;
    logic next_wdg;
    logic next_lp_entry;
    logic next_latch;
    logic next_latch_reset;
    logic stab_start;
    logic [12:0] stab_len;
    logic stab_done;
    logic apb_setup;
    logic apb_write;
    logic addr_ok;
    logic [31:0] read_word;

    // ==========================================================
    // instruction decode and mode choice
    // R10: halt opcode decode
    assign halt_exec = instr_exec && (instr_opcode == LPM_HALT_OPCODE);

    // R11: active halt enable from timer bits
    assign active_halt_en = ctrl.timebase_one_irq_enable ||
        (ctrl.overflow_irq_enable && !ctrl.timer_source_select_hi &&
        ctrl.timer_source_select_lo);

    // wake candidates per mode
    assign wait_hits = irq_pending;
    assign halt_hits = irq_pending & halt_wake;
    // R17: active halt wake sources
    assign act_hits = irq_pending & (act_wake | halt_wake);
    assign awu_hits = irq_pending & (halt_wake | LPM_AWU_WAKE);

    // ==========================================================
    // wake source picked for the current mode
    always_comb
    begin
        case (state)
            LPM_WAIT:
            begin
                sel_hits = wait_hits;
            end
            LPM_HALT:
            begin
                sel_hits = halt_hits;
            end
            LPM_ACT_HALT:
            begin
                sel_hits = act_hits;
            end
            LPM_AWU_HALT:
            begin
                sel_hits = awu_hits;
            end
            default:
            begin
                sel_hits = 14'h0000;
            end
        endcase
    end

    // lowest line wins
    always_comb
    begin
        sel_vec = 4'h0;
        sel_any = 1'b0;
        for (int i = LPM_IRQ_NUM - 1; i >= 0; i--)
        begin
            if (sel_hits[i])
            begin
                sel_vec = 4'(i);
                sel_any = 1'b1;
            end
        end
    end

    // ==========================================================
    // sequencer next state
    always_comb
    begin
        next_state = state;
        next_service = 1'b0;
        next_fetch = 1'b0;
        next_wdg = 1'b0;
        next_lp_entry = 1'b0;
        next_latch = 1'b0;
        next_latch_reset = 1'b0;
        stab_start = 1'b0;
        stab_len = LPM_STAB_SHORT_CYC;
        case (state)
            LPM_RUN:
            begin
                // R21: one mode, same cycle
                if (halt_exec)
                begin
                    if (active_halt_en)
                    begin
                        // R16: no watchdog reset here
                        next_state = LPM_ACT_HALT;
                        next_lp_entry = 1'b1;
                    end
                    else if (ctrl.watchdog_enable && !ctrl.watchdog_halt_option)
                    begin
                        // R9: watchdog reset instead of halt
                        next_wdg = 1'b1;
                    end
                    else if (ctrl.auto_wakeup_enable)
                    begin
                        // R20: auto wakeup halt
                        next_state = LPM_AWU_HALT;
                        next_lp_entry = 1'b1;
                    end
                    else
                    begin
                        // R5: plain halt
                        next_state = LPM_HALT;
                        next_lp_entry = 1'b1;
                    end
                end
                else if (wait_for_irq_op)
                begin
                    // R1: stop cpu only
                    next_state = LPM_WAIT;
                    next_lp_entry = 1'b1;
                end
            end
            LPM_WAIT:
            begin
                // R3: wake on reset or interrupt
                if (reset_req)
                begin
                    next_state = LPM_RUN;
                    next_fetch = 1'b1;
                end
                else if (sel_any)
                begin
                    next_state = LPM_RUN;
                    next_service = 1'b1;
                end
            end
            LPM_HALT, LPM_AWU_HALT:
            begin
                // R6: restart oscillator, then delay
                if (reset_req || sel_any)
                begin
                    next_state = LPM_STAB;
                    next_latch = 1'b1;
                    next_latch_reset = reset_req;
                    stab_start = 1'b1;
                    if (state == LPM_HALT && ctrl.long_stab)
                    begin
                        stab_len = LPM_STAB_LONG_CYC;
                    end
                end
            end
            LPM_ACT_HALT:
            begin
                if (reset_req)
                begin
                    // R12: fixed short delay on reset
                    next_state = LPM_STAB;
                    next_latch = 1'b1;
                    next_latch_reset = 1'b1;
                    stab_start = 1'b1;
                end
                else if (sel_any)
                begin
                    // R13: resume at once
                    next_state = LPM_RUN;
                    next_service = 1'b1;
                end
            end
            LPM_STAB:
            begin
                if (stab_done)
                begin
                    if (ctrl.pll_enable)
                    begin
                        // R18: hold for pll settling
                        next_state = LPM_PLL;
                        stab_start = 1'b1;
                        stab_len = LPM_PLL_SETTLE_CYC;
                    end
                    else
                    begin
                        next_state = LPM_RUN;
                        next_fetch = wake_by_reset;
                        next_service = !wake_by_reset;
                    end
                end
            end
            LPM_PLL:
            begin
                if (stab_done)
                begin
                    next_state = LPM_RUN;
                    next_fetch = wake_by_reset;
                    next_service = !wake_by_reset;
                end
            end
            default:
            begin
                next_state = LPM_RUN;
            end
        endcase
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= LPM_RUN;
        end
        else
        begin
            state <= next_state;
        end
    end

    // stabilization and pll settle counter
    lpm_stab_timer u_stab
    (
        .pclk(pclk),
        .presetn(presetn),
        .start(stab_start),
        .length(stab_len),
        .done(stab_done)
    );

    // wake cause held across the delay
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wake_vec <= 4'h0;
            wake_by_reset <= 1'b0;
        end
        else if (next_latch)
        begin
            wake_vec <= sel_vec;
            wake_by_reset <= next_latch_reset;
        end
    end

    // ==========================================================
    // wake outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_service <= 1'b0;
            irq_vector <= 4'h0;
            reset_fetch <= 1'b0;
            watchdog_reset_req <= 1'b0;
        end
        else
        begin
            irq_service <= next_service;
            // R3: vector of the waking source
            if (next_service)
            begin
                irq_vector <= (state == LPM_STAB || state == LPM_PLL) ? wake_vec : sel_vec;
            end
            reset_fetch <= next_fetch;
            watchdog_reset_req <= next_wdg;
        end
    end

    // interrupt mask bit, service set wins over pop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            condition_code_reg <= LPM_CC_I_RESET;
        end
        // R4: set during service routine
        else if (next_service)
        begin
            condition_code_reg <= 1'b1;
        end
        // R2: R7: R14: cleared on mode entry
        else if (next_lp_entry)
        begin
            condition_code_reg <= 1'b0;
        end
        // R4: cleared when popped
        else if (cc_pop)
        begin
            condition_code_reg <= 1'b0;
        end
    end

    // ==========================================================
    // clock gating from the next state
    always_comb
    begin
        next_clk = '0;
        case (next_state)
            LPM_RUN:
            begin
                next_clk = '{1'b1, 1'b1, 1'b1, 1'b1, ctrl.pll_enable};
            end
            LPM_WAIT:
            begin
                // R1: peripherals keep their clock
                next_clk = '{1'b0, 1'b1, 1'b1, 1'b1, ctrl.pll_enable};
            end
            LPM_ACT_HALT:
            begin
                // R15: oscillator and timer only
                next_clk = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
            end
            LPM_STAB, LPM_PLL:
            begin
                // R6: oscillator on during the delay
                next_clk = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
            end
            default:
            begin
                // R8: halt, everything off
                next_clk = '0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cpu_run <= 1'b1;
            periph_clk_en <= 1'b1;
            osc_en <= 1'b1;
            timer_clk_en <= 1'b1;
            pll_out_en <= 1'b0;
        end
        else
        begin
            cpu_run <= next_clk.cpu_run;
            periph_clk_en <= next_clk.periph_clk_en;
            osc_en <= next_clk.osc_en;
            timer_clk_en <= next_clk.timer_clk_en;
            pll_out_en <= next_clk.pll_out_en;
        end
    end

    // ==========================================================
    // apb slave, one wait-free access cycle
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite && pready;
    assign addr_ok = (paddr == LPM_REG_CTRL) || (paddr == LPM_REG_STATUS) ||
        (paddr == LPM_REG_HALT_WAKE) || (paddr == LPM_REG_ACT_WAKE);

    // read mux
    always_comb
    begin
        read_word = 32'h0000_0000;
        case (paddr)
            LPM_REG_CTRL:
            begin
                read_word[8:0] = ctrl;
            end
            LPM_REG_STATUS:
            begin
                read_word[LPM_STATUS_MODE_LSB +: 3] = state;
                read_word[LPM_STATUS_VEC_LSB +: 4] = wake_vec;
                read_word[LPM_STATUS_RST_BIT] = wake_by_reset;
                read_word[LPM_STATUS_CCI_BIT] = condition_code_reg;
            end
            LPM_REG_HALT_WAKE:
            begin
                read_word[13:0] = halt_wake;
            end
            LPM_REG_ACT_WAKE:
            begin
                read_word[13:0] = act_wake;
            end
            default:
            begin
                read_word = 32'h0000_0000;
            end
        endcase
    end

    // handshake and read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= apb_setup;
            pslverr <= apb_setup && !addr_ok;
            if (apb_setup && !pwrite)
            begin
                prdata <= read_word;
            end
        end
    end

    // writable registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= LPM_CTRL_RESET;
            halt_wake <= LPM_HALT_WAKE_RESET;
            act_wake <= LPM_ACT_WAKE_RESET;
        end
        else if (apb_write)
        begin
            case (paddr)
                LPM_REG_CTRL:
                begin
                    ctrl <= pwdata[8:0];
                end
                LPM_REG_HALT_WAKE:
                begin
                    halt_wake <= pwdata[13:0];
                end
                LPM_REG_ACT_WAKE:
                begin
                    act_wake <= pwdata[13:0];
                end
                default:
                begin
                    ctrl <= ctrl;
                end
            endcase
        end
    end

endmodule

//--- verification/lpm_ctrl_asserts.sv
`timescale 1ns/1ps
// ====
// port checks
module lpm_ctrl_chk
    import lpm_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bus and core side
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic instr_exec,
    input wire logic [7:0] instr_opcode,
    input wire logic wait_for_irq_op,
    input wire logic cc_pop,
    input wire logic [13:0] irq_pending,
    // results and enables
    input wire logic irq_service,
    input wire logic reset_fetch,
    input wire logic watchdog_reset_req,
    input wire logic condition_code_reg,
    input wire logic cpu_run,
    input wire logic periph_clk_en,
    input wire logic osc_en,
    input wire logic timer_clk_en
);
    logic from_halt;
    logic [12:0] stab_cnt;

    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ====
    // cycles since oscillator restart
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            from_halt <= 1'b0;
            stab_cnt <= 13'h0000;
        end
        else
        begin
            from_halt <= !osc_en || (from_halt && !cpu_run);
            stab_cnt <= !osc_en ? 13'h0000
                : stab_cnt + {12'h000, from_halt && !cpu_run && !stab_cnt[12]};
        end
    end

    // ====
    // assertions
    a_wait_entry: assert property (cpu_run && wait_for_irq_op |=> !cpu_run && periph_clk_en
        && osc_en && !condition_code_reg) else $error("wait entry wrong");
    a_wait_wake: assert property (!cpu_run && periph_clk_en && !from_halt
        && irq_pending != 14'h0000 |=> irq_service) else $error("wait not woken");
    a_service_mask: assert property (irq_service |-> cpu_run && condition_code_reg)
        else $error("service without mask");
    a_pop_clear: assert property (cc_pop && cpu_run |=> !condition_code_reg)
        else $error("pop kept mask");
    a_halt_mask: assert property (cpu_run && instr_exec && instr_opcode == LPM_HALT_OPCODE
        |=> !condition_code_reg || watchdog_reset_req) else $error("halt mask wrong");
    a_halt_gating: assert property (!osc_en |-> !cpu_run && !periph_clk_en && !timer_clk_en)
        else $error("halt clock on");
    a_stab_length: assert property ((irq_service || reset_fetch) && from_halt
        |-> stab_cnt >= 13'h0100) else $error("delay too short");
    a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready timing wrong");
endmodule

bind lpm_ctrl lpm_ctrl_chk chk_u (.pclk, .presetn, .psel, .penable, .pready, .instr_exec,
    .instr_opcode, .wait_for_irq_op, .cc_pop, .irq_pending, .irq_service, .reset_fetch,
    .watchdog_reset_req, .condition_code_reg, .cpu_run, .periph_clk_en, .osc_en, .timer_clk_en);

//--- verification/lpm_cpu_model.sv
`timescale 1ns/1ps
// ====
// cpu core and interrupt sources
module lpm_cpu_model
    import lpm_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench commands: 1 wait, 2 halt, 3 other
    input wire logic [1:0] op_req,
    input wire logic [13:0] irq_raise,
    // controller answers
    input wire logic irq_service,
    input wire logic [3:0] irq_vector,
    // core outputs
    output logic instr_exec,
    output logic [7:0] instr_opcode,
    output logic wait_for_irq_op,
    output logic cc_pop,
    output logic [13:0] irq_pending
);
    logic [2:0] pop_dly;

    // one instruction per request
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            instr_exec <= 1'b0;
            wait_for_irq_op <= 1'b0;
            instr_opcode <= 8'h62;
        end
        else
        begin
            instr_exec <= op_req[1];
            wait_for_irq_op <= op_req == 2'h1;
            instr_opcode <= op_req == 2'h2 ? LPM_HALT_OPCODE
                : (op_req == 2'h3 ? 8'h9d : instr_opcode + 8'h01);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_pending <= 14'h0000;
            pop_dly <= 3'h0;
            cc_pop <= 1'b0;
        end
        else
        begin
            irq_pending <= (irq_pending | irq_raise) & ~({13'h0000, irq_service} << irq_vector);
            pop_dly <= irq_service ? 3'h4 : pop_dly - {2'h0, pop_dly != 3'h0};
            cc_pop <= pop_dly == 3'h1;
        end
    end
endmodule

//--- verification/test_low_power_mode_controller.sv
`timescale 1ns/1ps
module test_low_power_mode_controller;
    import lpm_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [1:0] op_req = 2'h0;
    logic [13:0] irq_raise = 14'h0;
    logic reset_req = 1'b0;
    logic [31:0] prdata, q;
    logic [13:0] irq_pending;
    logic [7:0] instr_opcode;
    logic [3:0] irq_vector;
    logic pready, pslverr, instr_exec, wait_for_irq_op, cc_pop, irq_service, reset_fetch, e;
    logic watchdog_reset_req, condition_code_reg, cpu_run, periph_clk_en, osc_en, timer_clk_en;
    logic pll_out_en;
    int fails = 0;
    int checked = 0;
    int n;

    always #2.5 pclk = ~pclk;

    lpm_ctrl dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .instr_exec, .instr_opcode, .wait_for_irq_op, .cc_pop, .reset_req, .irq_pending,
        .irq_service, .irq_vector, .reset_fetch, .watchdog_reset_req, .condition_code_reg,
        .cpu_run, .periph_clk_en, .osc_en, .timer_clk_en, .pll_out_en);
    lpm_cpu_model cpu_u (.pclk, .presetn, .op_req, .irq_raise, .irq_service, .irq_vector,
        .instr_exec, .instr_opcode, .wait_for_irq_op, .cc_pop, .irq_pending);

    // ====
    // verdict and comparison
    task automatic complete_run();
        if (fails == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask

    // enables and mask
    function automatic logic [31:0] gates();
        return {27'h0, cpu_run, periph_clk_en, osc_en, timer_clk_en, condition_code_reg};
    endfunction

    // ====
    // apb transfer
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        #1;
        while (pready !== 1'b1 && k < 20)
        begin
            @(posedge pclk);
            #1;
            k++;
        end
        if (k == 20)
        begin
            fails++;
            complete_run();
        end
        q = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // write controls, run one op
    task automatic run_op(input logic [31:0] cfg, input logic [1:0] op, input int c);
        apb(1'b1, LPM_REG_CTRL, cfg);
        @(posedge pclk);
        op_req <= op;
        @(posedge pclk);
        op_req <= 2'h0;
        repeat (c) @(posedge pclk);
        #1;
    endtask

    // wake, count oscillator cycles
    task automatic wake(input logic [13:0] lines, input logic rst, input logic [7:0] exp,
        input logic [7:0] m, input int lo, input int hi);
        int i;
        @(posedge pclk);
        irq_raise <= lines;
        reset_req <= rst;
        #1;
        n = 0;
        for (i = 0; i < 5000 && (irq_service | reset_fetch | watchdog_reset_req) !== 1'b1; i++)
        begin
            @(posedge pclk);
            irq_raise <= 14'h0;
            #1;
            n += int'(osc_en === 1'b1);
        end
        if (i == 5000)
        begin
            fails++;
            complete_run();
        end
        q = {24'h0, irq_vector, condition_code_reg, watchdog_reset_req, reset_fetch, irq_service};
        cmp("wake_result", {24'h0, exp & m}, q & {24'h0, m});
        cmp("wake_cycles", lo, (n >= lo && n <= hi) ? lo : n);
        @(posedge pclk);
        reset_req <= 1'b0;
    endtask

    // ====
    // main sequence
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LPM_REG_HALT_WAKE, 32'h0);
        cmp("halt_wake", 32'h101e, q);
        apb(1'b0, LPM_REG_ACT_WAKE, 32'h0);
        cmp("act_wake", 32'h0a00, q);
        apb(1'b0, LPM_REG_STATUS, 32'h0);
        cmp("status", 32'h200, q & 32'h207);
        apb(1'b1, 8'h10, 32'hffffffff);
        cmp("slverr", 32'h1, {31'h0, e});
        apb(1'b1, LPM_REG_CTRL, 32'hffffffff);
        apb(1'b0, LPM_REG_CTRL, 32'h0);
        cmp("ctrl", 32'h1ff, q);
        run_op(32'h0, 2'h1, 2);
        cmp("wait_gates", 32'h0e, gates());
        wake(14'h0240, 1'b0, 8'h69, 8'hff, 2, 2);
        repeat (8) @(posedge pclk);
        cmp("popped", 32'h1e, gates());
        run_op(32'h0, 2'h3, 3);
        cmp("other_op", 32'h1e, gates());
        run_op(32'h0, 2'h2, 20);
        cmp("halt_gates", 32'h00, gates());
        wake(14'h0002, 1'b0, 8'h19, 8'hff, 258, 258);
        run_op(32'h80, 2'h2, 3);
        wake(14'h0, 1'b1, 8'h02, 8'h07, 4098, 4098);
        run_op(32'h70, 2'h2, 3);
        cmp("awu_gates", 32'h00, gates());
        wake(14'h0001, 1'b0, 8'h09, 8'hff, 258, 258);
        run_op(32'h40, 2'h2, 0);
        wake(14'h0, 1'b0, 8'h04, 8'h07, 0, 5);
        run_op(32'h41, 2'h2, 0);
        wake(14'h0, 1'b0, 8'h99, 8'hff, 0, 6);
        run_op(32'h46, 2'h2, 3);
        cmp("act_gates", 32'h06, gates());
        wake(14'h0840, 1'b0, 8'hb9, 8'hff, 2, 2);
        run_op(32'h01, 2'h2, 3);
        wake(14'h0, 1'b1, 8'h02, 8'h07, 257, 259);
        run_op(32'h4e, 2'h2, 0);
        wake(14'h0, 1'b0, 8'h04, 8'h07, 0, 5);
        run_op(32'h100, 2'h2, 3);
        wake(14'h0002, 1'b0, 8'h19, 8'hff, 458, 460);
        cmp("pll_out", 32'h1, {31'h0, pll_out_en});
        complete_run();
    end
endmodule
